// ---- common/ccu_regs.svh ----
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH

// register indices on the plain register port
`define CCU_ADDR_CONTROL    3'h0
`define CCU_ADDR_SOURCE     3'h1
`define CCU_ADDR_VALUE_LOW  3'h2
`define CCU_ADDR_VALUE_HIGH 3'h3
`define CCU_ADDR_FLAGS      3'h4

// field positions
`define CCU_CTRL_EN_BIT     7
`define CCU_CTRL_OUT_BIT    5
`define CCU_CTRL_FMT_BIT    4
`define CCU_FLAG_BIT        0
`define CCU_IRQ_EN_BIT      1

// reset values
`define CCU_CONTROL_RESET   8'h00
`define CCU_SOURCE_RESET    3'h0
`define CCU_VALUE_RESET     16'h0000
`define CCU_DUTY_RESET      10'h000

// capture edge prescaler terminal counts
`define CCU_PRESC_QUARTER   4'h3
`define CCU_PRESC_SIXTEENTH 4'hf

`endif

// ---- common/ccu_pkg.sv ----
package ccu_pkg;

  typedef enum logic [3:0]
  {
    CCU_OFF            = 4'b0000,
    CCU_CMP_TOGGLE_RST = 4'b0001,
    CCU_CMP_TOGGLE     = 4'b0010,
    CCU_CAP_FALL       = 4'b0100,
    CCU_CAP_RISE       = 4'b0101,
    CCU_CAP_RISE4      = 4'b0110,
    CCU_CAP_RISE16     = 4'b0111,
    CCU_CMP_SET        = 4'b1000,
    CCU_CMP_CLEAR      = 4'b1001,
    CCU_CMP_SOFT       = 4'b1010,
    CCU_CMP_TRIGGER    = 4'b1011,
    CCU_PWM            = 4'b1100
  } ccu_mode_type;

  typedef struct packed
  {
    logic        en;
    logic        fmt;
    logic [3:0]  mode;
    logic [2:0]  src_sel;
    logic [15:0] value;
    logic        flag;
    logic        irq_en;
    logic [7:0]  sync_a;
    logic [7:0]  sync_b;
    logic        src_prev;
    logic [3:0]  presc;
    logic        match_prev;
    logic        trig_pend;
    logic        out_level;
    logic [9:0]  duty_buf;
    logic        trigger;
    logic        timer_a_rst;
    logic [7:0]  rdata;
  } ccu_state_type;

endpackage : ccu_pkg

// ---- core/ccu_unit.sv ----
`timescale 1ns/10ps
`include "ccu_regs.svh"

module ccu_unit
#(
  parameter int TIMER_A_WIDTH = 16,
  parameter int SOURCE_COUNT  = 8
)
(
  // clock and reset
  input  wire logic                    MCLK_IN,
  input  wire logic                    RST_N_IN,
  // register port
  input  wire logic [2:0]              ADDR_IN,
  input  wire logic [7:0]              WDATA_IN,
  input  wire logic                    WR_IN,
  input  wire logic                    RD_IN,
  output logic      [7:0]              RDATA_OUT,
  // capture sources, asynchronous to the clock
  input  wire logic                    CAPTURE_PIN_IN,
  input  wire logic                    COMPARATOR_ONE_SYNC_IN,
  input  wire logic                    COMPARATOR_TWO_SYNC_IN,
  input  wire logic                    PIN_CHANGE_EVENT_IN,
  input  wire logic                    LOGIC_CELL_ONE_OUT_IN,
  input  wire logic                    LOGIC_CELL_TWO_OUT_IN,
  input  wire logic                    LOGIC_CELL_THREE_OUT_IN,
  input  wire logic                    LOGIC_CELL_FOUR_OUT_IN,
  // timer A
  input  wire logic [TIMER_A_WIDTH-1:0] TIMER_A_COUNT_IN,
  input  wire logic                    TIMER_A_EXT_CLOCK_IN,
  output logic                         TIMER_A_RESET_OUT,
  // timer B
  input  wire logic [7:0]              TIMER_B_COUNT_IN,
  input  wire logic [1:0]              TIMER_B_FRACTION_IN,
  input  wire logic                    TIMER_B_TICK_IN,
  input  wire logic [7:0]              PERIOD_LIMIT_IN,
  output logic                         TIMER_B_CLEAR_OUT,
  // system
  input  wire logic                    SLEEP_IN,
  input  wire logic                    TRIGGER_SELECT_IN,
  output logic                         TRIGGER_OUT,
  output logic                         EVENT_FLAG_OUT,
  output logic                         WAKE_OUT,
  // unit output
  output logic                         PIN_OUT,
  output logic                         UNIT_OUT
);
  import ccu_pkg::*;

  initial
  begin
    if (TIMER_A_WIDTH != 16 || SOURCE_COUNT != 8)
    begin
      $error("ccu_unit serves a 16-bit timer and eight sources only");
    end
  end

  ccu_state_type st;
  ccu_state_type next_st;
  ccu_mode_type  mode;
  logic [7:0]    src_raw;
  logic          cap_mode;
  logic          cmp_mode;
  logic          pwm_mode;
  logic          timer_active;
  logic          src_level;
  logic          rose;
  logic          fell;
  logic          cap_evt;
  logic          match_now;
  logic          cmp_hit;
  logic          period_hit;
  logic [9:0]    duty_val;
  logic [9:0]    time_base;
  logic          ctrl_zero_wr;

  // source order fixes the select encoding
  assign src_raw = {LOGIC_CELL_FOUR_OUT_IN, LOGIC_CELL_THREE_OUT_IN,
                    LOGIC_CELL_TWO_OUT_IN, LOGIC_CELL_ONE_OUT_IN,
                    PIN_CHANGE_EVENT_IN, COMPARATOR_TWO_SYNC_IN,
                    COMPARATOR_ONE_SYNC_IN, CAPTURE_PIN_IN};

  // reserved codes fall through every decode below and act as disabled
  assign mode     = ccu_mode_type'(st.mode);
  assign cap_mode = st.en && (st.mode[3:2] == 2'b01);
  assign pwm_mode = st.en && (mode == CCU_PWM);
  assign cmp_mode = st.en && (mode == CCU_CMP_TOGGLE_RST || mode == CCU_CMP_TOGGLE ||
                              mode == CCU_CMP_SET || mode == CCU_CMP_CLEAR ||
                              mode == CCU_CMP_SOFT || mode == CCU_CMP_TRIGGER);

  // the timer only moves in sleep when it has its own external clock
  assign timer_active = !SLEEP_IN || TIMER_A_EXT_CLOCK_IN;

  // a driven pin loops back through CAPTURE_PIN_IN, so port writes can capture
  assign src_level = st.sync_b[st.src_sel];
  assign rose      = src_level && !st.src_prev;
  assign fell      = !src_level && st.src_prev;

  always_comb
  begin
    cap_evt = 1'b0;
    if (cap_mode && timer_active)
    begin
      case (mode)
        CCU_CAP_FALL:   cap_evt = fell;
        CCU_CAP_RISE:   cap_evt = rose;
        CCU_CAP_RISE4:  cap_evt = rose && ({2'b00, st.presc[1:0]} == `CCU_PRESC_QUARTER);
        CCU_CAP_RISE16: cap_evt = rose && (st.presc == `CCU_PRESC_SIXTEENTH);
        default:        cap_evt = 1'b0;
      endcase
    end
  end

  assign match_now = (st.value == TIMER_A_COUNT_IN);
  // equality lasts while timer A holds a count, so act on its first cycle only
  assign cmp_hit   = cmp_mode && timer_active && match_now && !st.match_prev;

  assign duty_val   = st.fmt ? st.value[15:6] : st.value[9:0];
  assign time_base  = {TIMER_B_COUNT_IN, TIMER_B_FRACTION_IN};
  assign period_hit = pwm_mode && TIMER_B_TICK_IN &&
                      (TIMER_B_COUNT_IN == PERIOD_LIMIT_IN);
  assign ctrl_zero_wr = WR_IN && (ADDR_IN == `CCU_ADDR_CONTROL) && (WDATA_IN == 8'h00);

  always_comb
  begin
    next_st             = st;
    next_st.trigger     = 1'b0;
    next_st.timer_a_rst = 1'b0;
    next_st.rdata       = 8'h00;
    next_st.sync_a      = src_raw;
    next_st.sync_b      = st.sync_a;
    next_st.src_prev    = src_level;
    next_st.match_prev  = match_now && cmp_mode;

    // register writes; hardware events below take priority over them, except where a zero control write clears the output level
    if (WR_IN)
    begin
      case (ADDR_IN)
        `CCU_ADDR_CONTROL:
        begin
          next_st.en   = WDATA_IN[`CCU_CTRL_EN_BIT];
          next_st.fmt  = WDATA_IN[`CCU_CTRL_FMT_BIT];
          next_st.mode = WDATA_IN[3:0];
        end
        `CCU_ADDR_SOURCE:     next_st.src_sel     = WDATA_IN[2:0];
        `CCU_ADDR_VALUE_LOW:  next_st.value[7:0]  = WDATA_IN;
        `CCU_ADDR_VALUE_HIGH: next_st.value[15:8] = WDATA_IN;
        `CCU_ADDR_FLAGS:
        begin
          // flag is write-one-to-clear
          if (WDATA_IN[`CCU_FLAG_BIT])
          begin
            next_st.flag = 1'b0;
          end
          next_st.irq_en = WDATA_IN[`CCU_IRQ_EN_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // prescaler keeps counting across capture-to-capture mode switches
    if (!cap_mode)
    begin
      next_st.presc = 4'h0;
    end
    else if (rose)
    begin
      next_st.presc = st.presc + 4'h1;
    end

    if (cap_evt)
    begin
      next_st.value = TIMER_A_COUNT_IN;
      next_st.flag  = 1'b1;
    end

    if (cmp_hit)
    begin
      next_st.flag = 1'b1;
      case (mode)
        CCU_CMP_TOGGLE_RST,
        CCU_CMP_TOGGLE:  next_st.out_level = !st.out_level;
        CCU_CMP_SET:     next_st.out_level = 1'b1;
        CCU_CMP_CLEAR:   next_st.out_level = 1'b0;
        default:
        begin
        end
      endcase
      next_st.trigger   = TRIGGER_SELECT_IN;
      next_st.trig_pend = (mode == CCU_CMP_TRIGGER) || (mode == CCU_CMP_TOGGLE_RST);
    end
    else
    begin
      next_st.trig_pend = 1'b0;
    end

    // reset of timer A is dropped if the match went away in between
    if (st.trig_pend && match_now)
    begin
      next_st.timer_a_rst = 1'b1;
    end

    if (pwm_mode)
    begin
      if (period_hit)
      begin
        next_st.duty_buf  = duty_val;
        next_st.out_level = (duty_val != 10'h000);
      end
      else if (time_base == st.duty_buf)
      begin
        next_st.out_level = 1'b0;
      end
    end

    // a zero control write wins over any same-cycle match or period action on the output level
    if (ctrl_zero_wr)
    begin
      next_st.out_level = 1'b0;
    end

    if (RD_IN)
    begin
      case (ADDR_IN)
        `CCU_ADDR_CONTROL:    next_st.rdata = {st.en, 1'b0, st.out_level, st.fmt, st.mode};
        `CCU_ADDR_SOURCE:     next_st.rdata = {5'h00, st.src_sel};
        `CCU_ADDR_VALUE_LOW:  next_st.rdata = st.value[7:0];
        `CCU_ADDR_VALUE_HIGH: next_st.rdata = st.value[15:8];
        `CCU_ADDR_FLAGS:      next_st.rdata = {6'h00, st.irq_en, st.flag};
        default:              next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      st          <= '0;
      st.mode     <= 4'(`CCU_CONTROL_RESET);
      st.src_sel  <= `CCU_SOURCE_RESET;
      st.value    <= `CCU_VALUE_RESET;
      st.duty_buf <= `CCU_DUTY_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign RDATA_OUT         = st.rdata;
  assign TIMER_A_RESET_OUT = st.timer_a_rst;
  assign TIMER_B_CLEAR_OUT = period_hit;
  assign TRIGGER_OUT       = st.trigger;
  assign EVENT_FLAG_OUT    = st.flag;
  assign WAKE_OUT          = SLEEP_IN && st.flag && st.irq_en;
  assign PIN_OUT           = st.out_level;
  assign UNIT_OUT          = st.out_level;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  property p_capture_copies;
    cap_evt && !WR_IN |=> st.value == $past(TIMER_A_COUNT_IN);
  endproperty
  a_capture_copies: assert property (p_capture_copies)
    else $error("capture did not copy timer A");

  property p_quarter_edge;
    (cap_mode && mode == CCU_CAP_RISE4 && timer_active && rose &&
     st.presc[1:0] == 2'b11) |-> cap_evt;
  endproperty
  a_quarter_edge: assert property (p_quarter_edge)
    else $error("fourth rising edge did not capture");

  property p_capture_flag;
    cap_evt |=> st.flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag)
    else $error("capture did not set the flag");

  property p_presc_clear;
    !cap_mode |=> st.presc == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescaler kept counting outside capture");

  property p_match_flag;
    cmp_hit |=> st.flag && (TRIGGER_OUT == $past(TRIGGER_SELECT_IN));
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("compare match missed flag or trigger");

  property p_match_set;
    cmp_hit && mode == CCU_CMP_SET && !ctrl_zero_wr |=> PIN_OUT && UNIT_OUT;
  endproperty
  a_match_set: assert property (p_match_set)
    else $error("set on match did not raise the output");

  property p_zero_ctrl;
    ctrl_zero_wr |=> !PIN_OUT ##1 !PIN_OUT;
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl)
    else $error("zero control write left the latch high");

  property p_reset_cancel;
    TRIGGER_OUT && st.trig_pend && !match_now |=> !TIMER_A_RESET_OUT;
  endproperty
  a_reset_cancel: assert property (p_reset_cancel)
    else $error("timer A reset issued after match was removed");

  property p_period_load;
    period_hit && !ctrl_zero_wr |=>
      st.duty_buf == $past(duty_val) && PIN_OUT == ($past(duty_val) != 10'h000);
  endproperty
  a_period_load: assert property (p_period_load)
    else $error("period match did not load duty or set output");

  property p_duty_end;
    pwm_mode && !period_hit && time_base == st.duty_buf && !ctrl_zero_wr |=> !PIN_OUT;
  endproperty
  a_duty_end: assert property (p_duty_end)
    else $error("output stayed high past the duty point");

  property p_flag_sticky;
    st.flag && !(WR_IN && ADDR_IN == `CCU_ADDR_FLAGS && WDATA_IN[`CCU_FLAG_BIT]) |=> st.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("event flag cleared without a software write");

  property p_capture_overwrite;
    cap_evt && st.flag |=> st.value == $past(TIMER_A_COUNT_IN);
  endproperty
  a_capture_overwrite: assert property (p_capture_overwrite)
    else $error("unread capture was not overwritten");

  property p_duty_hold;
    !period_hit |=> st.duty_buf == $past(st.duty_buf);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty buffer changed away from a period match");

  property p_sleep_freeze;
    SLEEP_IN && !TIMER_A_EXT_CLOCK_IN |-> !cap_evt && !cmp_hit;
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("capture or compare acted while timer A was frozen");

  c_capture: cover property (cap_evt ##1 st.flag);
  c_compare: cover property (cmp_hit && mode == CCU_CMP_TOGGLE);
  c_trigger: cover property (TRIGGER_OUT ##1 TIMER_A_RESET_OUT);
  c_pwm:     cover property (period_hit ##[1:300] (pwm_mode && time_base == st.duty_buf));

endmodule : ccu_unit

// ---- test/ccu_partner.sv ----
`timescale 1ns/10ps

module ccu_partner_model
#(
  parameter logic [15:0] TA_START = 16'ha5c3
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // controls from the bench and the unit
  input  wire logic        hold_in,
  input  wire logic        sleep_in,
  input  wire logic        ext_clock_in,
  input  wire logic        timer_a_reset_in,
  input  wire logic        timer_b_clear_in,
  input  wire logic [7:0]  period_in,
  // timer counts
  output logic      [15:0] timer_a_out,
  output logic      [7:0]  timer_b_out,
  output logic      [1:0]  fraction_out,
  output logic             tick_out
);
  logic [1:0] div;

  assign fraction_out = div;
  assign tick_out     = (div == 2'h3);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div         <= 2'h0;
      timer_a_out <= TA_START;
      timer_b_out <= 8'h00;
    end
    else
    begin
      div <= div + 2'h1;
      // synchronous timer on the instruction clock
      // frozen in sleep unless clocked from outside
      if (timer_a_reset_in)
        timer_a_out <= 16'h0000;
      else if (tick_out && !hold_in && !(sleep_in && !ext_clock_in))
        timer_a_out <= timer_a_out + 16'h0001;
      // the increment after the period match clears timer B
      if (tick_out)
        timer_b_out <= (timer_b_clear_in || timer_b_out == period_in) ? 8'h00 :
                       timer_b_out + 8'h01;
    end
  end
endmodule : ccu_partner_model

// ---- test/ccu_unit_tb_top.sv ----
`timescale 1ns/10ps
`include "ccu_regs.svh"

module ccu_unit_tb_top;
  import ccu_pkg::*;
  logic        mclk, rst_n, wr, rd, hold, sleep, ext, tsel;
  logic [2:0]  addr;
  logic [7:0]  wdata, src, rdata, tbc, per;
  logic [15:0] ta, t;
  logic [1:0]  frac;
  logic        tick, ta_rst, tb_clr, trig, flag, wake, pin, uout;
  logic [3:0]  cm[7] = '{CCU_CMP_SET, CCU_CMP_CLEAR, CCU_CMP_TOGGLE, CCU_CMP_TOGGLE_RST,
                         CCU_CMP_SET, CCU_CMP_SOFT, CCU_CMP_TRIGGER};
  logic        cp[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [15:0] dv[5] = '{16'h0000, 16'h0005, 16'h0009, 16'h0010, 16'h0240};
  logic [3:0]  m;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, trig_n = 0, arst_n = 0, n, n0, a0;
  int          w[5], clr_w = 0;

  ccu_unit uut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CAPTURE_PIN_IN(src[0]),
    .COMPARATOR_ONE_SYNC_IN(src[1]), .COMPARATOR_TWO_SYNC_IN(src[2]),
    .PIN_CHANGE_EVENT_IN(src[3]), .LOGIC_CELL_ONE_OUT_IN(src[4]),
    .LOGIC_CELL_TWO_OUT_IN(src[5]), .LOGIC_CELL_THREE_OUT_IN(src[6]),
    .LOGIC_CELL_FOUR_OUT_IN(src[7]), .TIMER_A_COUNT_IN(ta), .TIMER_A_EXT_CLOCK_IN(ext),
    .TIMER_A_RESET_OUT(ta_rst), .TIMER_B_COUNT_IN(tbc), .TIMER_B_FRACTION_IN(frac),
    .TIMER_B_TICK_IN(tick), .PERIOD_LIMIT_IN(per), .TIMER_B_CLEAR_OUT(tb_clr),
    .SLEEP_IN(sleep), .TRIGGER_SELECT_IN(tsel), .TRIGGER_OUT(trig), .EVENT_FLAG_OUT(flag),
    .WAKE_OUT(wake), .PIN_OUT(pin), .UNIT_OUT(uout));

  ccu_partner_model partner (.clk_in(mclk), .rst_n_in(rst_n), .hold_in(hold), .sleep_in(sleep),
    .ext_clock_in(ext), .timer_a_reset_in(ta_rst), .timer_b_clear_in(tb_clr), .period_in(per),
    .timer_a_out(ta), .timer_b_out(tbc), .fraction_out(frac), .tick_out(tick));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    trig_n += int'(trig === 1'b1);
    arst_n += int'(ta_rst === 1'b1);
    // generous ceiling; the whole sequence needs about fifteen hundred cycles
    if (cyc == 12000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ticks(input int k);
    repeat (k) @(posedge mclk);
  endtask : ticks

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask : rd_reg

  task automatic set_val(input logic [15:0] v);
    wr_reg(`CCU_ADDR_VALUE_LOW, v[7:0]);
    wr_reg(`CCU_ADDR_VALUE_HIGH, v[15:8]);
  endtask : set_val

  // zero the control first so the edge prescaler starts clean
  task automatic mode(input logic [3:0] md);
    wr_reg(`CCU_ADDR_CONTROL, 8'h00);
    wr_reg(`CCU_ADDR_CONTROL, {4'h8, md});
    wr_reg(`CCU_ADDR_FLAGS, 8'h01);
  endtask : mode

  task automatic edge_on(input int s, input logic lv);
    @(posedge mclk);
    src[s] <= lv;
    ticks(5);
  endtask : edge_on

  task automatic pulse(input int s, input int k);
    repeat (k)
    begin
      edge_on(s, 1'b1);
      edge_on(s, 1'b0);
    end
  endtask : pulse

  initial
  begin
    {rst_n, wr, rd, hold, sleep, ext} = 6'h00;
    {addr, wdata, src, tsel, per} = {3'h0, 8'h00, 8'h00, 1'b1, 8'h03};
    ticks(16);
    rst_n <= 1'b1;
    wr_reg(3'h5, 8'hff);
    for (int a = 0; a < 8; a++) rd_reg(3'(a), 8'h00);
    hold <= 1'b1;
    mode(CCU_CAP_RISE);
    pulse(0, 1);
    ticks(9);
    rd_reg(`CCU_ADDR_FLAGS, 8'h01);
    chk(16'(flag), 16'h0001);
    hold <= 1'b0;
    ticks(9);
    hold <= 1'b1;
    ticks(2);
    t = ta;
    pulse(0, 1);
    rd_reg(`CCU_ADDR_VALUE_LOW, t[7:0]);
    rd_reg(`CCU_ADDR_VALUE_HIGH, t[15:8]);
    wr_reg(`CCU_ADDR_FLAGS, 8'h01);
    rd_reg(`CCU_ADDR_FLAGS, 8'h00);
    chk(16'(flag), 16'h0000);
    mode(CCU_CAP_FALL);
    edge_on(0, 1'b1);
    rd_reg(`CCU_ADDR_FLAGS, 8'h00);
    edge_on(0, 1'b0);
    rd_reg(`CCU_ADDR_FLAGS, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      n = (i == 0) ? 4 : 16;
      m = (i == 0) ? CCU_CAP_RISE4 : CCU_CAP_RISE16;
      mode(m);
      pulse(0, n - 1);
      mode(m);
      pulse(0, n - 1);
      rd_reg(`CCU_ADDR_FLAGS, 8'h00);
      pulse(0, 1);
      rd_reg(`CCU_ADDR_FLAGS, 8'h01);
    end
    for (int s = 0; s < 8; s++)
    begin
      wr_reg(`CCU_ADDR_SOURCE, 8'(s));
      mode(CCU_CAP_RISE);
      pulse((s + 1) % 8, 1);
      rd_reg(`CCU_ADDR_FLAGS, 8'h00);
      pulse(s, 1);
      rd_reg(`CCU_ADDR_FLAGS, 8'h01);
    end
    wr_reg(`CCU_ADDR_SOURCE, 8'h00);
    mode(CCU_CAP_RISE);
    wr_reg(`CCU_ADDR_FLAGS, 8'h03);
    sleep <= 1'b1;
    pulse(0, 1);
    rd_reg(`CCU_ADDR_FLAGS, 8'h02);
    chk(16'(wake), 16'h0000);
    @(posedge mclk);
    ext <= 1'b1;
    pulse(0, 1);
    rd_reg(`CCU_ADDR_FLAGS, 8'h03);
    chk(16'(wake), 16'h0001);
    @(posedge mclk);
    {sleep, ext} <= 2'b00;
    mode(CCU_OFF);
    wr_reg(`CCU_ADDR_CONTROL, 8'h00);
    n0 = trig_n;
    for (int i = 0; i < 7; i++)
    begin
      hold <= 1'b1;
      ticks(2);
      t = ta;
      set_val(t + 16'h0001);
      wr_reg(`CCU_ADDR_CONTROL, {4'h8, cm[i]});
      wr_reg(`CCU_ADDR_FLAGS, 8'h01);
      hold <= 1'b0;
      ticks(8);
      hold <= 1'b1;
      rd_reg(`CCU_ADDR_FLAGS, 8'h01);
      chk(16'(pin), 16'(cp[i]));
      chk(16'(uout), 16'(cp[i]));
    end
    chk(16'(trig_n - n0), 16'h0007);
    chk(16'(arst_n), 16'h0002);
    wr_reg(`CCU_ADDR_CONTROL, 8'h00);
    ticks(2);
    chk(16'(pin), 16'h0000);
    wr_reg(`CCU_ADDR_CONTROL, {4'h8, CCU_CMP_TRIGGER});
    for (int k = 0; k < 2; k++)
    begin
      ticks(2);
      t = ta;
      set_val(t ^ 16'h000f);
      {n0, a0} = {trig_n, arst_n};
      @(posedge mclk);
      {wr, addr, wdata} <= {1'b1, `CCU_ADDR_VALUE_LOW, t[7:0]};
      @(posedge mclk);
      wdata <= (k == 0) ? t[7:0] + 8'h01 : t[7:0];
      @(posedge mclk);
      wr <= 1'b0;
      ticks(6);
      chk(16'(trig_n - n0), 16'h0001);
      chk(16'(arst_n - a0), 16'(k));
    end
    hold <= 1'b0;
    wr_reg(`CCU_ADDR_CONTROL, {4'h8, CCU_PWM});
    for (int i = 0; i < 5; i++)
    begin
      // last pass repeats the duty of the third pass in left-aligned form
      if (i == 4)
        wr_reg(`CCU_ADDR_CONTROL, 8'h9c);
      set_val(dv[i]);
      ticks(48);
      w[i] = 0;
      repeat (16)
      begin
        @(posedge mclk);
        #1;
        w[i] += int'(pin === 1'b1);
        clr_w += int'(tb_clr === 1'b1);
      end
    end
    chk(16'(w[0]), 16'h0000);
    chk(16'(w[3]), 16'h0010);
    chk(16'(w[2] - w[1]), 16'h0004);
    chk(16'(w[4]), 16'(w[2]));
    chk(16'(clr_w), 16'h0005);
    test_done();
  end
endmodule : ccu_unit_tb_top
